/* File: common/rcd_pkg.sv */
// shared constants and carrier types for the reset cause and debug force reset block
package rcd_pkg;
	localparam int RCD_DATA_W = 8;
	localparam int RCD_ADDR_W = 2;
	// register index within the block's local address window
	localparam logic [1:0] RCD_ADDR_CAUSE = 2'h0;
	localparam logic [1:0] RCD_ADDR_FORCE = 2'h1;
	// reset cause flag positions, and the force bit position in the force register
	localparam int RCD_BIT_POWER_ON = 7;
	localparam int RCD_BIT_PIN = 6;
	localparam int RCD_BIT_WATCHDOG = 5;
	localparam int RCD_BIT_ILLEGAL_OPCODE = 4;
	localparam int RCD_BIT_ILLEGAL_ADDRESS = 3;
	localparam int RCD_BIT_LOW_VOLTAGE = 1;
	localparam int RCD_BIT_FORCE = 0;
	localparam logic [7:0] RCD_CAUSE_IMPL_MASK = 8'hFA;
	localparam logic [7:0] RCD_ZERO = 8'h00;
	// cycles the internal reset request stays asserted; a debug forced reset holds it one cycle longer
	localparam int RCD_RESET_PULSE = 4;
	localparam int RCD_CNT_W = 3;

	typedef struct packed {
		logic power_on;
		logic pin;
		logic watchdog;
		logic illegal_opcode;
		logic illegal_address;
		logic low_voltage;
		logic debug_force;
	} rcd_cause_t;

	typedef struct packed {
		logic cpu_write;
		logic cpu_read;
		logic debug_write;
		logic [RCD_ADDR_W-1:0] addr;
		logic [RCD_DATA_W-1:0] wdata;
	} rcd_bus_t;

	typedef enum logic [1:0] {
		RCD_RUN = 2'b00,
		RCD_HOLD = 2'b01,
		RCD_SAMPLE = 2'b10
	} rcd_state_t;
endpackage

/* File: rtl/rcd_sync.sv */
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/100ps
module rcd_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_out;

	always_comb begin
		next_out = sync_out;
		for (int i = 0; i < WIDTH; i++) begin
			if (stage2[i] == stage3[i]) begin
				next_out[i] = stage3[i];
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			stage1 <= INIT;
			stage2 <= INIT;
			stage3 <= INIT;
			sync_out <= INIT;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
			sync_out <= next_out;
		end
	end
endmodule

/* File: rtl/rcd_top.sv */
// reset cause flag register and debug forced reset logic
`timescale 1ns/100ps
// How it works
// RULE1 - The reset cause register holds read-only flags naming the source of the latest reset.
// RULE2 - A reset forced by the debug host clears every flag in the reset cause register.
// RULE3 - Any write to the reset cause address restarts the watchdog and leaves the flags alone.
// RULE4 - On reset entry each flag takes whether its source is active at that moment.
// RULE5 - Power-on reset sets bit 7 and also the low-voltage flag in bit 1.
// RULE6 - A low level on the external reset pin sets the pin flag in bit 6.
// RULE7 - A watchdog timeout sets bit 5, and no such reset happens while the watchdog is disabled.
// RULE8 - Executing an unimplemented or illegal opcode resets and sets bit 4.
// RULE9 - Stop with stop mode disabled, or background with background mode disabled, counts as illegal opcode.
// RULE10 - Accessing an unimplemented address resets and sets bit 3.
// RULE11 - A supply below the trip level with low-voltage reset enabled resets and sets bit 1.
// RULE12 - Bits 2 and 0 of the reset cause register read as zero.
// RULE13 - Writes to the force register from the user program are ignored; only debug writes count.
// RULE14 - Reading the force register always returns zero.
// RULE15 - A debug write of 1 to bit 0 of the force register performs a full reset.
// RULE16 - After the forcing write the debug host holds the mode pin high for user mode or low for debug mode.
// RULE17 - Watchdog enable at 0 disables the watchdog; at 1 a timeout forces a reset.
module rcd_top
	import rcd_pkg::*;
#(
	parameter int RESET_PULSE = RCD_RESET_PULSE
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic power_on_reset,
	input wire logic reset_pin_n,
	input wire logic watchdog_timeout,
	input wire logic watchdog_enable,
	input wire logic illegal_opcode,
	input wire logic stop_executed,
	input wire logic stop_mode_enable,
	input wire logic enter_background_instruction,
	input wire logic background_mode_enable,
	input wire logic illegal_address,
	input wire logic low_voltage_detect,
	input wire logic low_voltage_reset_enable,
	input wire logic debug_mode_select_pin,
	input wire rcd_pkg::rcd_bus_t bus,
	output logic [rcd_pkg::RCD_DATA_W-1:0] rdata,
	output logic watchdog_restart,
	output logic mcu_reset,
	output logic background_debug_mode
);
	import rcd_pkg::*;

	logic [1:0] pin_raw;
	logic [1:0] pin_sync;
	logic reset_pin_level_n;
	logic mode_pin_level;
	rcd_state_t state;
	rcd_state_t next_state;
	logic [RCD_CNT_W-1:0] count;
	logic [RCD_CNT_W-1:0] next_count;
	logic [RCD_DATA_W-1:0] cause_flags;
	logic [RCD_DATA_W-1:0] next_cause_flags;
	rcd_cause_t latched;
	rcd_cause_t next_latched;
	rcd_cause_t active;
	logic [RCD_DATA_W-1:0] next_rdata;
	logic next_watchdog_restart;
	logic next_mcu_reset;
	logic next_background_debug_mode;
	logic force_hit;

	function automatic logic [RCD_DATA_W-1:0] cause_to_flags(input rcd_cause_t c);
		logic [RCD_DATA_W-1:0] f;
		f = RCD_ZERO;
		if (!c.debug_force) begin
			f[RCD_BIT_POWER_ON] = c.power_on; // RULE5
			f[RCD_BIT_PIN] = c.pin; // RULE6
			f[RCD_BIT_WATCHDOG] = c.watchdog; // RULE7
			f[RCD_BIT_ILLEGAL_OPCODE] = c.illegal_opcode; // RULE8
			f[RCD_BIT_ILLEGAL_ADDRESS] = c.illegal_address; // RULE10
			f[RCD_BIT_LOW_VOLTAGE] = c.low_voltage | c.power_on; // RULE5 RULE11
		end
		return f & RCD_CAUSE_IMPL_MASK; // RULE12
	endfunction

	assign pin_raw = {reset_pin_n, debug_mode_select_pin};

	// pins come from outside the clock domain
	rcd_sync #(
		.WIDTH(2),
		.INIT(2'h3)
	) u_pin_sync (
		.clock(clock),
		.resetn(resetn),
		.async_in(pin_raw),
		.sync_out(pin_sync)
	);

	assign reset_pin_level_n = pin_sync[1];
	assign mode_pin_level = pin_sync[0];

	// debug-only write; cpu writes to this address never reach here
	assign force_hit = bus.debug_write && (bus.addr == RCD_ADDR_FORCE) && bus.wdata[RCD_BIT_FORCE]; // RULE13 RULE15

	always_comb begin
		active = '0;
		active.power_on = power_on_reset;
		active.pin = !reset_pin_level_n; // RULE6
		active.watchdog = watchdog_timeout && watchdog_enable; // RULE7 RULE17
		active.illegal_opcode = illegal_opcode
			|| (stop_executed && !stop_mode_enable)
			|| (enter_background_instruction && !background_mode_enable); // RULE8 RULE9
		active.illegal_address = illegal_address; // RULE10
		active.low_voltage = low_voltage_detect && low_voltage_reset_enable; // RULE11
		active.debug_force = force_hit; // RULE2
	end

	always_comb begin
		next_state = state;
		next_count = count;
		next_latched = latched;
		next_cause_flags = cause_flags;
		next_mcu_reset = mcu_reset;
		next_background_debug_mode = background_debug_mode;
		case (state)
			RCD_RUN: begin
				if (active != '0) begin
					// reset entry: all flags replaced at once
					next_latched = active;
					next_cause_flags = cause_to_flags(active); // RULE4 RULE1 RULE2
					next_state = RCD_HOLD;
					next_count = RCD_CNT_W'(RESET_PULSE - 1);
					next_mcu_reset = 1'b1; // RULE15
				end
			end
			RCD_HOLD: begin
				if (count != '0) begin
					next_count = count - 1'b1;
				end else if (latched.debug_force) begin
					next_state = RCD_SAMPLE;
				end else begin
					next_state = RCD_RUN;
					next_mcu_reset = 1'b0;
					next_background_debug_mode = 1'b0;
				end
			end
			RCD_SAMPLE: begin
				// host is holding the pin by now, so one look suffices
				next_background_debug_mode = !mode_pin_level; // RULE16
				next_mcu_reset = 1'b0;
				next_state = RCD_RUN;
			end
			default: begin
				next_state = RCD_RUN;
				next_mcu_reset = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state <= RCD_RUN;
			count <= '0;
			latched <= '0;
			cause_flags <= RCD_ZERO;
			mcu_reset <= 1'b0;
			background_debug_mode <= 1'b0;
		end else begin
			state <= next_state;
			count <= next_count;
			latched <= next_latched;
			cause_flags <= next_cause_flags;
			mcu_reset <= next_mcu_reset;
			background_debug_mode <= next_background_debug_mode;
		end
	end

	always_comb begin
		next_watchdog_restart = 1'b0;
		next_rdata = RCD_ZERO;
		if ((bus.cpu_write || bus.debug_write) && bus.addr == RCD_ADDR_CAUSE) begin
			next_watchdog_restart = 1'b1; // RULE3
		end
		if (bus.cpu_read) begin
			case (bus.addr)
				RCD_ADDR_CAUSE: next_rdata = cause_flags; // RULE1
				RCD_ADDR_FORCE: next_rdata = RCD_ZERO; // RULE14
				default: next_rdata = RCD_ZERO;
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdata <= RCD_ZERO;
			watchdog_restart <= 1'b0;
		end else begin
			rdata <= next_rdata;
			watchdog_restart <= next_watchdog_restart;
		end
	end
endmodule

/* File: verification/rcd_props.sv */
// assertions on the reset cause block ports
`timescale 1ns/100ps
module rcd_props import rcd_pkg::*; #(parameter int RESET_PULSE = RCD_RESET_PULSE) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic power_on_reset,
	input wire logic illegal_opcode,
	input wire logic illegal_address,
	input wire logic debug_mode_select_pin,
	input wire rcd_pkg::rcd_bus_t bus,
	input wire logic [7:0] rdata,
	input wire logic watchdog_restart,
	input wire logic mcu_reset,
	input wire logic background_debug_mode
);
	int hi_cnt;
	logic wr_cause;
	logic forced;
	assign wr_cause = (bus.cpu_write || bus.debug_write) && bus.addr == RCD_ADDR_CAUSE;
	assign forced = bus.debug_write && bus.addr == RCD_ADDR_FORCE && bus.wdata[0];
	// edges seen with the request high, to tell plain from forced releases
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			hi_cnt <= 0;
		end else begin
			hi_cnt <= mcu_reset ? hi_cnt + 1 : 0;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	sequence s_run; !mcu_reset && !$past(mcu_reset); endsequence
	sequence s_end; $fell(mcu_reset); endsequence
	cause_entry_a: assert property (s_run ##0 (power_on_reset || illegal_opcode || illegal_address) |=> mcu_reset)
		else $error("cause ignored");
	forced_entry_a: assert property (s_run ##0 forced |=> mcu_reset) else $error("force ignored");
	force_read_a: assert property (bus.cpu_read && bus.addr == RCD_ADDR_FORCE |=> rdata == RCD_ZERO)
		else $error("force read");
	spare_bits_a: assert property (!rdata[2] && !rdata[0]) else $error("spare bits set");
	restart_pulse_a: assert property (wr_cause |=> watchdog_restart) else $error("restart missing");
	restart_only_a: assert property (!wr_cause |=> !watchdog_restart) else $error("restart stray");
	hold_len_a: assert property (s_end |-> hi_cnt == RESET_PULSE || hi_cnt == RESET_PULSE + 1)
		else $error("reset length");
	mode_pick_a: assert property (s_end ##0 hi_cnt > RESET_PULSE
		|-> background_debug_mode != debug_mode_select_pin) else $error("mode wrong");
endmodule
bind rcd_top rcd_props #(.RESET_PULSE(RESET_PULSE)) u_props (
	.clock(clock),
	.resetn(resetn),
	.power_on_reset(power_on_reset),
	.illegal_opcode(illegal_opcode),
	.illegal_address(illegal_address),
	.debug_mode_select_pin(debug_mode_select_pin),
	.bus(bus),
	.rdata(rdata),
	.watchdog_restart(watchdog_restart),
	.mcu_reset(mcu_reset),
	.background_debug_mode(background_debug_mode)
);

/* File: verification/rcd_host.sv */
// debug host model: forcing write, with the mode pin driven on the same edge and held after
`timescale 1ns/100ps
module rcd_host import rcd_pkg::*; (
	input wire logic clock,
	input wire logic go,
	input wire logic user_mode,
	output rcd_pkg::rcd_bus_t hbus = '0,
	output logic debug_mode_select_pin = 1'b1
);
	always @(posedge clock) begin
		hbus <= go ? {3'b001, RCD_ADDR_FORCE, 8'h01} : '0;
		if (go) begin
			debug_mode_select_pin <= user_mode;
		end
	end
endmodule

/* File: verification/tb_top.sv */
// self-checking bench for the reset cause block
`timescale 1ns/100ps
module tb_top;
	import rcd_pkg::*;
	logic clock = 1'b0, resetn = 1'b0, go = 1'b0, user_mode = 1'b1;
	logic [7:0] src = 8'h00;
	logic [3:0] en = 4'h9;
	rcd_bus_t tbus = '0, hbus, bus;
	logic power_on_reset, reset_pin_n, watchdog_timeout, illegal_opcode, illegal_address, low_voltage_detect;
	logic stop_executed, enter_background_instruction, watchdog_enable, stop_mode_enable, background_mode_enable;
	logic low_voltage_reset_enable, debug_mode_select_pin, watchdog_restart, mcu_reset, background_debug_mode;
	logic [7:0] rdata;
	int fails = 0, num_checks = 0;
	// pin source inverted: the pin is active low
	assign {power_on_reset, reset_pin_n, watchdog_timeout, illegal_opcode, illegal_address, low_voltage_detect,
		stop_executed, enter_background_instruction} = src ^ 8'h40;
	assign {watchdog_enable, stop_mode_enable, background_mode_enable, low_voltage_reset_enable} = en;
	assign bus = hbus.debug_write ? hbus : tbus;
	rcd_top dut (
		.clock(clock),
		.resetn(resetn),
		.power_on_reset(power_on_reset),
		.reset_pin_n(reset_pin_n),
		.watchdog_timeout(watchdog_timeout),
		.watchdog_enable(watchdog_enable),
		.illegal_opcode(illegal_opcode),
		.stop_executed(stop_executed),
		.stop_mode_enable(stop_mode_enable),
		.enter_background_instruction(enter_background_instruction),
		.background_mode_enable(background_mode_enable),
		.illegal_address(illegal_address),
		.low_voltage_detect(low_voltage_detect),
		.low_voltage_reset_enable(low_voltage_reset_enable),
		.debug_mode_select_pin(debug_mode_select_pin),
		.bus(bus),
		.rdata(rdata),
		.watchdog_restart(watchdog_restart),
		.mcu_reset(mcu_reset),
		.background_debug_mode(background_debug_mode)
	);
	rcd_host host (.clock(clock), .go(go), .user_mode(user_mode), .hbus(hbus),
		.debug_mode_select_pin(debug_mode_select_pin));
	always #12.5 clock = ~clock;
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task automatic acc(input logic [2:0] k, input logic [1:0] a, input logic [7:0] d, input logic [7:0] exp);
		@(posedge clock);
		tbus <= {k, a, d};
		@(posedge clock);
		tbus <= '0;
		#1;
		chk(k[1] ? rdata : {7'h00, watchdog_restart}, exp);
	endtask
	// sources held three cycles so the synchronised pin gets through
	task automatic hit(input logic [11:0] se, input logic [7:0] exp);
		@(posedge clock);
		src <= se[11:4];
		en <= se[3:0];
		repeat (3) @(posedge clock);
		src <= 8'h00;
		repeat (12) @(posedge clock);
		acc(3'b010, RCD_ADDR_CAUSE, 8'h00, exp);
	endtask
	task automatic frc(input logic m, input logic [7:0] exp);
		@(posedge clock);
		go <= 1'b1;
		user_mode <= m;
		@(posedge clock);
		go <= 1'b0;
		// host strobe is taken one edge later, so the request stands after the second edge
		repeat (2) @(posedge clock);
		#1;
		chk({7'h00, mcu_reset}, 8'h01);
		repeat (10) @(posedge clock);
		acc(3'b010, RCD_ADDR_CAUSE, 8'h00, exp);
		chk({7'h00, background_debug_mode}, {7'h00, !m});
	endtask
	task automatic complete_run();
		if (fails == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clock);
		resetn <= 1'b1;
		hit(12'h809, 8'h82);
		hit(12'h409, 8'h40);
		hit(12'h209, 8'h20);
		hit(12'h109, 8'h10);
		hit(12'h089, 8'h08);
		hit(12'h029, 8'h10);
		hit(12'h049, 8'h02);
		hit(12'h019, 8'h10);
		hit(12'h189, 8'h18);
		hit(12'h276, 8'h18);
		acc(3'b100, RCD_ADDR_CAUSE, 8'hFF, 8'h01);
		acc(3'b010, RCD_ADDR_CAUSE, 8'h00, 8'h18);
		acc(3'b100, RCD_ADDR_FORCE, 8'h01, 8'h00);
		hit(12'h009, 8'h18);
		acc(3'b010, RCD_ADDR_FORCE, 8'h00, 8'h00);
		acc(3'b010, 2'h2, 8'h00, 8'h00);
		frc(1'b1, 8'h00);
		hit(12'h089, 8'h08);
		frc(1'b0, 8'h00);
		@(posedge clock);
		resetn <= 1'b0;
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		acc(3'b010, RCD_ADDR_CAUSE, 8'h00, 8'h00);
		complete_run();
	end
	initial begin
		repeat (3000) @(posedge clock);
		fails++;
		complete_run();
	end
endmodule
